// File: ccmb_consts.vh
// Constants for the processor configuration register bank
`ifndef CCMB_CONSTS_VH
`define CCMB_CONSTS_VH
`define CCMB_ADDR_W           32
`define CCMB_OFS_CYCLE        32'h0000_0010
`define CCMB_OFS_INTC         32'h0000_001B
`define CCMB_OFS_POWERON      32'h0000_002A
`define CCMB_OFS_RANGE_DEF    32'h0000_02FF
`define CCMB_RANGE_EN_BIT     11
`define CCMB_FIXED_EN_BIT     10
`define CCMB_MEMKIND_LSB      0
`define CCMB_MEMKIND_MSB      7
`define CCMB_RANGE_DEF_MASK   64'h0000_0000_0000_0CFF
`define CCMB_INTC_ADDR_LSB    12
`define CCMB_INTC_ADDR_MSB    39
`define CCMB_INTC_EN_BIT      11
`define CCMB_INTC_BOOT_BIT    8
`define CCMB_INTC_MASK        64'h0000_00FF_FFFF_F900
`define CCMB_INTC_ADDR_RST    28'h00F_EE00
`define CCMB_CLUSTER_LSB      16
`define CCMB_CLUSTER_MSB      17
`define CCMB_CYCLE_RST        64'h0000_0000_0000_0000
`endif

// File: ccmb_cycle_counter.v
// Free-running 64-bit cycle counter with software load
module ccmb_cycle_counter (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Software load
  input  wire        load,
  input  wire [63:0] load_val,
  // Count value
  output wire [63:0] count
);
`include "ccmb_consts.vh"
  reg [63:0] cnt_ff;
  wire [63:0] nxt_cnt;

  // Wraps naturally at the 64-bit width, no flag produced
  assign nxt_cnt = load ? load_val : cnt_ff + 64'h0000_0000_0000_0001;

  always @(posedge clk) begin
    if (rst) begin
      cnt_ff <= `CCMB_CYCLE_RST;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign count = cnt_ff;
endmodule // ccmb_cycle_counter

// File: ccmb_msr_bank.v
// Processor configuration register bank: range typing, intc base, counter
module ccmb_msr_bank (
  // Clock and reset
  input  wire        CLK_SYS,
  input  wire        RST,
  // Strap inputs
  input  wire        BOOT_STRAP,
  input  wire [1:0]  CLUSTER_ID_IN,
  // Register access
  input  wire        REG_RD,
  input  wire        REG_WR,
  input  wire [31:0] REG_ADDR,
  input  wire [63:0] REG_WDATA,
  output reg  [63:0] REG_RDATA,
  output reg         REG_ACK,
  output reg         GENERAL_PROTECTION_FAULT,
  // Configuration outputs
  output wire        RANGE_TYPING_ENABLE,
  output wire        FIXED_RANGE_ENABLE,
  output wire [7:0]  DEFAULT_MEM_KIND,
  output wire [27:0] INTC_BASE_ADDR,
  output wire        INTC_ENABLE,
  output wire        INTC_BOOT_CPU,
  output wire [1:0]  INTC_CLUSTER_ID,
  output wire [63:0] CYCLE_COUNT
);
`include "ccmb_consts.vh"

  // Defined memory kinds: 0,1,4,5,6; others are undefined
  function kind_ok;
    input [7:0] k;
    begin
      kind_ok = (k == 8'h00) || (k == 8'h01) ||
                (k >= 8'h04 && k <= 8'h06);
    end
  endfunction

  function hit;
    input [31:0] a;
    input [31:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  reg        range_en_ff;
  reg        fixed_en_ff;
  reg [7:0]  mem_kind_ff;
  reg [27:0] intc_addr_ff;
  reg        intc_en_ff;
  reg        boot_ff;
  reg        boot_cap_ff;
  reg [1:0]  cluster_ff;

  wire sel_cyc  = hit(REG_ADDR, `CCMB_OFS_CYCLE);
  wire sel_intc = hit(REG_ADDR, `CCMB_OFS_INTC);
  wire sel_pwr  = hit(REG_ADDR, `CCMB_OFS_POWERON);
  wire sel_def  = hit(REG_ADDR, `CCMB_OFS_RANGE_DEF);
  wire sel_any  = sel_cyc | sel_intc | sel_pwr | sel_def;

  wire def_bad  = |(REG_WDATA & ~`CCMB_RANGE_DEF_MASK) |
                  ~kind_ok(REG_WDATA[`CCMB_MEMKIND_MSB:`CCMB_MEMKIND_LSB]);
  wire intc_bad = |(REG_WDATA & ~`CCMB_INTC_MASK);
  wire wr_fault = REG_WR & ((sel_def & def_bad) | (sel_intc & intc_bad) |
                            sel_pwr | ~sel_any);
  wire wr_ok    = REG_WR & ~wr_fault;
  wire rd_fault = REG_RD & ~REG_WR & ~sel_any;

  wire [63:0] def_view  = {52'h0_0000_0000_0000, range_en_ff, fixed_en_ff,
                           2'b00, mem_kind_ff};
  wire [63:0] intc_view = {24'h00_0000, intc_addr_ff, intc_en_ff, 2'b00,
                           boot_ff, 8'h00};
  wire [63:0] pwr_view  = {46'h0000_0000_0000, cluster_ff, 16'h0000};
  wire [63:0] cyc_val;

  ccmb_cycle_counter u_cycle (
    .clk      (CLK_SYS),
    .rst      (RST),
    .load     (wr_ok & sel_cyc),
    .load_val (REG_WDATA),
    .count    (cyc_val)
  );

  // Boot flag and cluster id are caught one edge after reset release
  always @(posedge CLK_SYS) begin
    if (RST) begin
      boot_cap_ff <= 1'b0;
    end else begin
      boot_cap_ff <= 1'b1;
    end
  end

  always @(posedge CLK_SYS) begin
    if (RST) begin
      range_en_ff  <= 1'b0;
      fixed_en_ff  <= 1'b0;
      mem_kind_ff  <= 8'h00;
      intc_addr_ff <= `CCMB_INTC_ADDR_RST;
      intc_en_ff   <= 1'b0;
      boot_ff      <= 1'b0;
      cluster_ff   <= 2'b00;
    end else begin
      if (!boot_cap_ff) begin
        boot_ff    <= BOOT_STRAP;
        cluster_ff <= CLUSTER_ID_IN;
      end else if (wr_ok && sel_intc) begin
        boot_ff    <= REG_WDATA[`CCMB_INTC_BOOT_BIT];
      end
      if (wr_ok && sel_def) begin
        range_en_ff <= REG_WDATA[`CCMB_RANGE_EN_BIT];
        fixed_en_ff <= REG_WDATA[`CCMB_FIXED_EN_BIT];
        mem_kind_ff <= REG_WDATA[`CCMB_MEMKIND_MSB:`CCMB_MEMKIND_LSB];
      end
      if (wr_ok && sel_intc) begin
        intc_addr_ff <= REG_WDATA[`CCMB_INTC_ADDR_MSB:`CCMB_INTC_ADDR_LSB];
        intc_en_ff   <= REG_WDATA[`CCMB_INTC_EN_BIT];
      end
    end
  end

  // One-cycle answer registered after each access
  always @(posedge CLK_SYS) begin
    if (RST) begin
      REG_RDATA                <= 64'h0000_0000_0000_0000;
      REG_ACK                  <= 1'b0;
      GENERAL_PROTECTION_FAULT <= 1'b0;
    end else begin
      REG_ACK                  <= REG_RD | REG_WR;
      GENERAL_PROTECTION_FAULT <= wr_fault | rd_fault;
      if (REG_RD && !REG_WR) begin
        REG_RDATA <= sel_def  ? def_view :
                     sel_intc ? intc_view :
                     sel_pwr  ? pwr_view :
                     sel_cyc  ? cyc_val : 64'h0000_0000_0000_0000;
      end
    end
  end

  // Only the fixed-range enable is gated, by range typing enable, so downstream never sees it set alone
  assign RANGE_TYPING_ENABLE = range_en_ff;
  assign FIXED_RANGE_ENABLE  = range_en_ff & fixed_en_ff;
  assign DEFAULT_MEM_KIND    = mem_kind_ff;
  assign INTC_BASE_ADDR      = intc_addr_ff;
  assign INTC_ENABLE         = intc_en_ff;
  assign INTC_BOOT_CPU       = boot_ff;
  assign INTC_CLUSTER_ID     = cluster_ff;
  assign CYCLE_COUNT         = cyc_val;
endmodule // ccmb_msr_bank

// File: ccmb_msr_bank_asserts.sv
// Checker for the configuration register bank
`include "ccmb_consts.vh"
module ccmb_msr_bank_chk (
  input wire        CLK_SYS, RST, REG_WR, GENERAL_PROTECTION_FAULT,
  input wire        RANGE_TYPING_ENABLE, FIXED_RANGE_ENABLE, INTC_ENABLE,
  input wire [31:0] REG_ADDR,
  input wire [63:0] REG_WDATA, CYCLE_COUNT,
  input wire [7:0]  DEFAULT_MEM_KIND,
  input wire [27:0] INTC_BASE_ADDR,
  input wire [1:0]  INTC_CLUSTER_ID
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  wire [63:0] w  = REG_WDATA;
  wire        gp = GENERAL_PROTECTION_FAULT;
  wire        wc = REG_WR && REG_ADDR == `CCMB_OFS_CYCLE;
  wire        wi = REG_WR && REG_ADDR == `CCMB_OFS_INTC;
  wire        wf = REG_WR && REG_ADDR == `CCMB_OFS_RANGE_DEF;
  wire        io = (w & ~`CCMB_INTC_MASK) == 64'h0;
  // Only kinds 0, 1, 4, 5 and 6 are defined
  wire        fo = (w & ~`CCMB_RANGE_DEF_MASK) == 64'h0 && w[7:0] inside
                   {8'h00, 8'h01, 8'h04, 8'h05, 8'h06};
  AST_CNT: assert property (
    !$past(RST) && !$past(wc) |-> CYCLE_COUNT == $past(CYCLE_COUNT) + 64'h1)
    else $error("count step");
  AST_PWR: assert property (
    REG_WR && REG_ADDR == `CCMB_OFS_POWERON |=> gp) else $error("no fault");
  AST_IBAD: assert property (
    wi && !io |=> gp && $stable(INTC_BASE_ADDR)) else $error("intc kept");
  AST_IOK: assert property (
    wi && io |=> !gp && INTC_BASE_ADDR == $past(w[39:12]) &&
    INTC_ENABLE == $past(w[11])) else $error("intc write");
  AST_FBAD: assert property (
    wf && !fo |=> gp && $stable(DEFAULT_MEM_KIND)) else $error("kind kept");
  AST_FOK: assert property (
    wf && fo |=> !gp && RANGE_TYPING_ENABLE == $past(w[11]) &&
    DEFAULT_MEM_KIND == $past(w[7:0])) else $error("default write");
  AST_FIX: assert property (
    FIXED_RANGE_ENABLE |-> RANGE_TYPING_ENABLE) else $error("fixed alone");
  AST_CLUS: assert property (
    !$past(RST) && !$past(RST, 2) |-> $stable(INTC_CLUSTER_ID))
    else $error("cluster moved");
  C_GP: cover property (gp);
  C_FIX: cover property (wf && fo && w[11:10] == 2'b11);
  C_WRAP: cover property (CYCLE_COUNT == 64'h0 && !$past(RST));
endmodule // ccmb_msr_bank_chk
bind ccmb_msr_bank ccmb_msr_bank_chk ccmb_msr_bank_chk_i (.CLK_SYS(CLK_SYS),
  .RST(RST), .REG_WR(REG_WR), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .GENERAL_PROTECTION_FAULT(GENERAL_PROTECTION_FAULT),
  .RANGE_TYPING_ENABLE(RANGE_TYPING_ENABLE),
  .FIXED_RANGE_ENABLE(FIXED_RANGE_ENABLE), .INTC_ENABLE(INTC_ENABLE),
  .DEFAULT_MEM_KIND(DEFAULT_MEM_KIND), .INTC_BASE_ADDR(INTC_BASE_ADDR),
  .INTC_CLUSTER_ID(INTC_CLUSTER_ID), .CYCLE_COUNT(CYCLE_COUNT));

// File: tb_ccmb_msr_bank.sv
// Bench for the configuration register bank
`include "ccmb_consts.vh"
module tb_ccmb_msr_bank;
  timeunit 1ns;
  timeprecision 1ns;
  reg          clk, rst, rd, wr, bs;
  reg   [1:0]  cl;
  reg   [31:0] ad;
  reg   [63:0] wd, d, im, dm;
  wire  [63:0] rdat;
  wire         ack, gp;
  logic [65:0] q[$];
  logic [65:0] n;
  int          mismatches = 0, samples_checked = 0, i;
  ccmb_msr_bank ccmb_msr_bank_i (.CLK_SYS(clk), .RST(rst), .BOOT_STRAP(bs),
    .CLUSTER_ID_IN(cl), .REG_RD(rd), .REG_WR(wr), .REG_ADDR(ad),
    .REG_WDATA(wd), .REG_RDATA(rdat), .REG_ACK(ack),
    .GENERAL_PROTECTION_FAULT(gp), .RANGE_TYPING_ENABLE(),
    .FIXED_RANGE_ENABLE(), .DEFAULT_MEM_KIND(), .INTC_BASE_ADDR(),
    .INTC_ENABLE(), .INTC_BOOT_CPU(), .INTC_CLUSTER_ID(), .CYCLE_COUNT());
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic cmp(string nm, logic [63:0] e, logic [63:0] s);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Note layout: read flag, fault, expected read data
  // Answers are looked at mid-cycle, where they have settled
  always @(negedge clk) if (ack === 1'b1) begin
    if (q.size() == 0) cmp("spare ack", 64'h0, 64'h1);
    else begin
      n = q.pop_front();
      cmp("fault", {63'h0, n[64]}, {63'h0, gp});
      if (n[65]) cmp("rdata", n[63:0], rdat);
    end
  end
  task automatic acc(bit r, logic [31:0] a, logic [63:0] v, logic [63:0] e,
                     bit f);
    @(negedge clk);
    {rd, wr, ad, wd} <= {r, !r, a, v};
    q.push_back({r, f, e});
    @(negedge clk);
    {rd, wr} <= 2'b00;
  endtask
  task print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    i = $urandom(32'h3c0f);
    {rst, rd, wr, ad, wd, dm} = {3'b100, 160'h0};
    cl = 2'($urandom);
    bs = 1'($urandom);
    im = 64'h0000_0000_FEE0_0000 | 64'(bs) << 8;
    repeat (3) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    acc(1, `CCMB_OFS_INTC, $urandom, im, 0);
    acc(1, `CCMB_OFS_RANGE_DEF, $urandom, dm, 0);
    for (i = 0; i < 2; i++) begin
      acc(i, `CCMB_OFS_POWERON, 64'h3_0000, {46'h0, cl, 16'h0}, !i);
    end
    acc(1, 32'h0000_0011, $urandom, 64'h0, 1);
    // Odd passes set one reserved bit, low then high
    for (i = 0; i < 4; i++) begin
      d = {$urandom, $urandom} & `CCMB_INTC_MASK |
          64'(i % 2) << (9 + i / 2 * 40);
      acc(0, `CCMB_OFS_INTC, d, 64'h0, i % 2);
      if (i % 2 == 0) im = d;
      acc(1, `CCMB_OFS_INTC, $urandom, im, 0);
    end
    for (i = 0; i <= 8; i++) begin
      d = {$urandom, $urandom} & 64'h0C00 | 64'(i % 8) | 64'(i / 8) << 12;
      acc(0, `CCMB_OFS_RANGE_DEF, d, 64'h0, i inside {2, 3, 7, 8});
      if (!(i inside {2, 3, 7, 8})) dm = d;
      acc(1, `CCMB_OFS_RANGE_DEF, $urandom, dm, 0);
    end
    acc(0, `CCMB_OFS_CYCLE, 64'hFFFF_FFFF_FFFF_FFFE, 64'h0, 0);
    acc(1, `CCMB_OFS_CYCLE, $urandom, 64'hFFFF_FFFF_FFFF_FFFF, 0);
    acc(1, `CCMB_OFS_CYCLE, $urandom, 64'h0000_0000_0000_0001, 0);
    repeat (2) @(posedge clk);
    #1 if (q.size() != 0) cmp("pending", 64'h0, 64'h1);
    print_verdict;
  end
endmodule // tb_ccmb_msr_bank
